/* File: logic/asop_fifo.sv */
// Purpose: Result FIFO with valid/ready on both sides
// Assumes: Synchronous, single clock
// Notes: Depth must be a power of two
`timescale 1ns/10ps
module asop_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("asop_fifo depth must be power of two");
  end
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;
  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = wr_q + (AW+1)'(push);
    rd_d = rd_q + (AW+1)'(pop);
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end
  always_ff @(posedge clk)
  begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end
  assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_q != rd_q;
  assign out_data = mem_q[rd_q[AW-1:0]];
endmodule : asop_fifo

/* File: logic/asop_pkg.sv */
// Purpose: Shared constants and types for the converter serial output port
// Assumes: 100 MHz system clock
// Notes: Result width and master clock divider are parameters of the top
package asop_pkg;
  localparam int RESULT_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 10;
  // Master serial clock half period
  localparam int MCLK_HALF_NS = 20;
  localparam int MCLK_HALF_CYC = (MCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [4:0] BITCNT_RST = 5'h00;

  typedef struct packed {
    logic serial_parallel_select;
    logic clk_src;
    logic clk_inv;
    logic sync_pol;
    logic coding;
  } asop_cfg_t;

  typedef struct packed {
    logic [2:0] o;
    logic [2:0] oe;
  } asop_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_SHIFT = 2'b10,
    ST_DONE = 2'b11
  } asop_state_t;
endpackage : asop_pkg

/* File: logic/asop_port.sv */
// Purpose: Serial or parallel output of conversion results on three shared pins
// Assumes: Pins and serial clock asynchronous to clk; results arrive on a stream
// Notes: Slave serial clock is oversampled, so it must be below clk/8
`timescale 1ns/10ps
module asop_port #(
  parameter int RESULT_W = asop_pkg::RESULT_W,
  parameter int HALF_CYC = asop_pkg::MCLK_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic res_valid,
  output logic res_ready,
  input wire logic [RESULT_W-1:0] res_data,
  input wire asop_pkg::asop_cfg_t cfg,
  input wire logic cs_b,
  input wire logic rd_b,
  input wire logic sclk_i,
  output asop_pkg::asop_pins_t pins,
  output logic busy_frame
);
  initial
  begin
    if (RESULT_W < 11 || RESULT_W > 31) $error("asop_port result width out of range");
    if (HALF_CYC < 1 || HALF_CYC > 255) $error("asop_port half period out of range");
  end

  // Reset release synchroniser
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Two-flop synchronisers for pins
  localparam int NS = 8;
  logic [NS-1:0] s1_q, s2_q, pin_raw;
  assign pin_raw = {cfg.serial_parallel_select, cfg.clk_src, cfg.clk_inv, cfg.sync_pol, cfg.coding,
                    cs_b, rd_b, sclk_i};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= 8'h06;
      s2_q <= 8'h06;
    end
    else
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end
  logic ser, slave, inv, spol, ob, cs_n, rd_n, sck;
  assign {ser, slave, inv, spol, ob, cs_n, rd_n, sck} = s2_q;

  // Result FIFO
  logic f_valid, f_ready;
  logic [RESULT_W-1:0] f_data;
  asop_fifo #(.W(RESULT_W), .DEPTH(asop_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_n),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .in_data(res_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  function automatic logic [RESULT_W-1:0] code(input logic [RESULT_W-1:0] v, input logic bin);
    code = bin ? {~v[RESULT_W-1], v[RESULT_W-2:0]} : v;
  endfunction : code

  logic enable;
  assign enable = !cs_n && !rd_n;

  // Serial engine state
  asop_pkg::asop_state_t st_q, st_d;
  logic [RESULT_W-1:0] sh_q, sh_d, par_q, par_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] div_q, div_d;
  logic mclk_q, mclk_d, sck_q, sck_d, sdo_q, sdo_d;
  asop_pkg::asop_pins_t pins_d;
  logic upd_edge, smp_edge, mrise, mfall;

  always_comb
  begin
    st_d = st_q;
    sh_d = sh_q;
    par_d = par_q;
    cnt_d = cnt_q;
    div_d = div_q;
    mclk_d = mclk_q;
    sck_d = sck;
    sdo_d = sdo_q;
    f_ready = 1'b0;
    mrise = 1'b0;
    mfall = 1'b0;
    // Slave edges, gated by chip select
    upd_edge = !cs_n && (inv ? (sck_q && !sck) : (!sck_q && sck));
    smp_edge = !cs_n && (inv ? (!sck_q && sck) : (sck_q && !sck));
    if (!ser && f_valid)
    begin
      f_ready = 1'b1;
      par_d = code(f_data, ob);
    end
    unique case (st_q)
      asop_pkg::ST_IDLE:
      begin
        mclk_d = 1'b0;
        div_d = 8'h00;
        if (ser && enable && f_valid)
        begin
          f_ready = 1'b1;
          sh_d = code(f_data, ob);
          st_d = asop_pkg::ST_LOAD;
        end
      end
      asop_pkg::ST_LOAD:
      begin
        sdo_d = sh_q[RESULT_W-1];
        if (slave)
        begin
          // Slave frames repeat the MSB on the first update edge
          cnt_d = 5'(RESULT_W);
        end
        else
        begin
          sh_d = {sh_q[RESULT_W-2:0], 1'b0};
          cnt_d = 5'(RESULT_W - 1);
        end
        st_d = asop_pkg::ST_SHIFT;
      end
      asop_pkg::ST_SHIFT:
      begin
        if (!slave)
        begin
          // Master clock: data moves only after the falling edge
          if (div_q == 8'(HALF_CYC - 1))
          begin
            div_d = 8'h00;
            mclk_d = !mclk_q;
            mrise = !mclk_q;
            mfall = mclk_q;
          end
          else div_d = div_q + 8'h01;
        end
        if ((slave && upd_edge && !smp_edge) || mfall)
        begin
          if (cnt_q == 5'h00) st_d = asop_pkg::ST_DONE;
          else
          begin
            sdo_d = sh_q[RESULT_W-1];
            sh_d = {sh_q[RESULT_W-2:0], 1'b0};
            cnt_d = cnt_q - 5'h01;
          end
        end
        if (!enable) st_d = asop_pkg::ST_IDLE;
      end
      asop_pkg::ST_DONE:
      begin
        mclk_d = 1'b0;
        if (!enable) st_d = asop_pkg::ST_IDLE;
      end
    endcase
    // Pin mux
    pins_d.oe = enable ? 3'h7 : 3'h0;
    if (!ser)
    begin
      pins_d.o = par_q[10:8];
    end
    else
    begin
      pins_d.o[0] = sdo_q;
      pins_d.o[1] = mclk_d ^ inv;
      pins_d.o[2] = (st_q == asop_pkg::ST_SHIFT) ^ spol;
      if (slave)
      begin
        pins_d.oe[1] = 1'b0;
        pins_d.oe[2] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= asop_pkg::ST_IDLE;
      sh_q <= asop_pkg::RESULT_RST;
      par_q <= asop_pkg::RESULT_RST;
      cnt_q <= asop_pkg::BITCNT_RST;
      div_q <= 8'h00;
      mclk_q <= 1'b0;
      sck_q <= 1'b0;
      sdo_q <= 1'b0;
      pins <= '0;
      busy_frame <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      sh_q <= sh_d;
      par_q <= par_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      mclk_q <= mclk_d;
      sck_q <= sck_d;
      sdo_q <= sdo_d;
      pins <= pins_d;
      busy_frame <= st_d != asop_pkg::ST_IDLE;
    end
  end

  a_drivers_off: assert property (@(posedge clk) disable iff (!rst_n)
    !enable |=> pins.oe == 3'h0) else $error("drivers on without select");
  a_par_bits: assert property (@(posedge clk) disable iff (!rst_n)
    !ser |=> pins.o == $past(par_q[10:8])) else $error("parallel bits wrong");
  a_par_drain: assert property (@(posedge clk) disable iff (!rst_n)
    (!ser && f_valid) |-> f_ready) else $error("parallel result not taken");
  a_par_value: assert property (@(posedge clk) disable iff (!rst_n)
    (!ser && f_valid) |=> par_q[10:8] == $past(f_data[10:8]))
    else $error("parallel result bits wrong");
  a_ser_data_pin: assert property (@(posedge clk) disable iff (!rst_n)
    ser |=> pins.o[0] == $past(sdo_q)) else $error("serial data pin wrong");
  a_master_stable: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == asop_pkg::ST_SHIFT && !slave && mrise) |=> $stable(sdo_q))
    else $error("data moved on rising master edge");
  a_master_shift: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == asop_pkg::ST_SHIFT && mfall && cnt_q != 5'h00) |=>
    sdo_q == $past(sh_q[RESULT_W-1])) else $error("master bit not advanced");
  a_sync_level: assert property (@(posedge clk) disable iff (!rst_n)
    (ser && !slave && st_q == asop_pkg::ST_SHIFT) |=> pins.o[2] == !$past(spol))
    else $error("frame sync level wrong");
  a_sync_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (ser && !slave && st_q != asop_pkg::ST_SHIFT) |=> pins.o[2] == $past(spol))
    else $error("frame sync not idle");
  a_sync_off_slave: assert property (@(posedge clk) disable iff (!rst_n)
    (ser && slave) |=> !pins.oe[2]) else $error("slave sync pin driven");
  a_slave_clk_in: assert property (@(posedge clk) disable iff (!rst_n)
    (ser && slave) |=> !pins.oe[1]) else $error("slave clock pin driven");
  a_clk_out_master: assert property (@(posedge clk) disable iff (!rst_n)
    (ser && !slave && enable) |=> pins.oe[1]) else $error("master clock pin not driven");
  a_clk_pin_level: assert property (@(posedge clk) disable iff (!rst_n)
    (ser && !slave) |=> pins.o[1] == (mclk_q ^ $past(inv)))
    else $error("master clock pin wrong");
  a_half_period: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == asop_pkg::ST_SHIFT && !slave) |-> div_q <= 8'(HALF_CYC - 1))
    else $error("master divider overrun");
  a_slave_step: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == asop_pkg::ST_SHIFT && slave && upd_edge && enable && cnt_q != 5'h00) |=>
    cnt_q == $past(cnt_q) - 5'h01) else $error("slave edge not counted");
  a_slave_mclk_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == asop_pkg::ST_SHIFT && slave) |=> $stable(mclk_q))
    else $error("master clock ran in slave mode");
  a_cs_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (slave && cs_n && st_q == asop_pkg::ST_SHIFT) |=> $stable(sdo_q))
    else $error("shift without chip select");
  a_word_len: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == asop_pkg::ST_LOAD) |=>
    cnt_q == ($past(slave) ? 5'(RESULT_W) : 5'(RESULT_W - 1)))
    else $error("frame length wrong");
  a_done_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == asop_pkg::ST_DONE) |=> $stable(sdo_q)) else $error("data moved after frame");
  a_done_busy: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == asop_pkg::ST_DONE) |-> busy_frame) else $error("finished frame not flagged");
  a_abort_idle: assert property (@(posedge clk) disable iff (!rst_n)
    ((st_q == asop_pkg::ST_SHIFT || st_q == asop_pkg::ST_DONE) && !enable) |=>
    st_q == asop_pkg::ST_IDLE) else $error("frame not ended on release");
  a_msb_first: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == asop_pkg::ST_LOAD) |=> sdo_q == $past(sh_q[RESULT_W-1]))
    else $error("first bit not msb");
  a_slave_first: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == asop_pkg::ST_LOAD && slave) |=> sh_q == $past(sh_q))
    else $error("slave word shifted before first edge");
  a_coding_msb: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == asop_pkg::ST_IDLE && ser && enable && f_valid) |=>
    sh_q[RESULT_W-1] == ($past(f_data[RESULT_W-1]) ^ $past(ob)))
    else $error("coded sign bit wrong");
  a_coding_low: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == asop_pkg::ST_IDLE && ser && enable && f_valid) |=>
    sh_q[RESULT_W-2:0] == $past(f_data[RESULT_W-2:0])) else $error("result bits changed");
  a_slave_upd: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == asop_pkg::ST_SHIFT && slave && smp_edge && enable) |=> $stable(sdo_q))
    else $error("data moved on sample edge");
endmodule : asop_port

/* File: tb/asop_host.sv */
// Purpose: Host controller model reading results from the serial port
// Assumes: Slave clock of 125 ns period, only within a frame
// Notes: Master mode bits are taken while frame sync is active
`timescale 1ns/10ps
module asop_host (
  input wire logic go,
  input wire logic inv,
  input wire logic master,
  input wire logic sync_pol,
  input wire asop_pkg::asop_pins_t pins,
  output logic sclk,
  output logic [15:0] word,
  output int nbits,
  output int errs
);
  logic last_bit;
  logic lead_clk;
  assign lead_clk = pins.o[1] ^ inv;
  initial
  begin
    sclk = 1'b0;
    word = 16'h0000;
    nbits = 0;
    errs = 0;
    last_bit = 1'b0;
  end
  // Slave clock stands at its idle level outside a frame
  always @(posedge go)
  begin
    word = 16'h0000;
    nbits = 0;
    if (!master)
    begin
      sclk = inv;
      #200;
      repeat (16)
      begin
        #62.5 sclk = ~inv;
        #62.5 sclk = inv;
        word = {word[14:0], pins.oe[0] ? pins.o[0] : ~pins.o[0]};
        nbits++;
      end
    end
  end
  // Master mode: sample on the leading pin clock edge, recheck on the trailing one
  always @(posedge lead_clk)
  begin
    if (master && pins.oe[1] && pins.o[2] === ~sync_pol)
    begin
      word = {word[14:0], pins.oe[0] ? pins.o[0] : ~pins.o[0]};
      last_bit = pins.o[0];
      nbits++;
    end
  end
  always @(negedge lead_clk)
  begin
    if (master && pins.oe[1] && nbits > 0 && pins.o[2] === ~sync_pol
        && pins.o[0] !== last_bit)
      errs++;
  end
endmodule : asop_host

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the serial output port
// Assumes: Default result width and master clock divider
// Notes: Rows hold config and result word; fill and drain follow
`timescale 1ns/10ps
module tb_top;
  logic clk, rst_b, res_valid, res_ready, cs_b, rd_b, sclk, busy_frame, go;
  logic [15:0] res_data, word;
  asop_pkg::asop_cfg_t cfg;
  asop_pkg::asop_pins_t pins;
  int nbits, errs, failures, checks_done;
  logic [20:0] rows [7];
  bit ok;

  asop_port u_asop_port (.clk(clk), .rst_b(rst_b), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data), .cfg(cfg), .cs_b(cs_b), .rd_b(rd_b),
    .sclk_i(sclk), .pins(pins), .busy_frame(busy_frame));
  asop_host u_asop_host (.go(go), .inv(cfg.clk_inv), .master(~cfg.clk_src),
    .sync_pol(cfg.sync_pol), .pins(pins), .sclk(sclk), .word(word), .nbits(nbits),
    .errs(errs));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : cmp

  task automatic print_verdict();
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic push(input logic [15:0] d, output bit taken);
    taken = 1'b0;
    @(posedge clk);
    res_valid <= 1'b1;
    res_data <= d;
    for (int i = 0; i < 4 && !taken; i++)
    begin
      @(negedge clk);
      taken = (res_ready === 1'b1);
      @(posedge clk);
    end
    res_valid <= 1'b0;
  endtask : push

  task automatic run_row(input logic [20:0] r);
    logic [15:0] exp;
    exp = r[15:0] ^ {r[16], 15'h0000};
    cfg <= r[20:16];
    tick(4);
    push(r[15:0], ok);
    tick(8);
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    cs_b <= 1'b0;
    rd_b <= 1'b0;
    if (r[20])
    begin
      for (int i = 0; i < 400 && nbits < 16; i++)
        tick(1);
      tick(20);
      cmp(word, exp, "serial word");
      cmp(16'(nbits), 16'h0010, "bits per frame");
      cmp(16'(pins.oe), r[19] ? 16'h0001 : 16'h0007, "serial drivers");
      cmp(16'(busy_frame), 16'h0001, "frame held");
    end
    else
    begin
      tick(8);
      cmp(16'(pins.o), 16'(exp[10:8]), "parallel bits");
      cmp(16'(pins.oe), 16'h0007, "parallel drivers");
    end
    cs_b <= 1'b1;
    rd_b <= 1'b1;
    tick(6);
    cmp(16'(pins.oe), 16'h0000, "released drivers");
  endtask : run_row

  initial
  begin
    #200000;
    failures++;
    print_verdict();
  end

  initial
  begin
    rst_b = 1'b0;
    res_valid = 1'b0;
    res_data = 16'h0000;
    cfg = 5'h00;
    cs_b = 1'b1;
    rd_b = 1'b1;
    go = 1'b0;
    failures = 0;
    checks_done = 0;
    rows = '{{5'h10, 16'ha5c3}, {5'h13, 16'h8001}, {5'h14, 16'h5a3c}, {5'h18, 16'h3c96},
      {5'h1d, 16'hf00f}, {5'h00, 16'h0500}, {5'h01, 16'h0700}};
    tick(2);
    cmp(16'(pins.oe), 16'h0000, "drivers in reset");
    tick(1);
    rst_b <= 1'b1;
    tick(4);
    foreach (rows[i])
      run_row(rows[i]);
    cmp(16'(errs), 16'h0000, "master bit held across edges");
    // Fill the result queue with no reader until it refuses
    cfg <= 5'h10;
    tick(4);
    for (int k = 0; k < 9; k++)
    begin
      push(16'h0600 ^ (16'(k) << 8), ok);
      cmp(16'(ok), 16'(k < 8), "queue acceptance");
    end
    // Parallel mode drains the queue; last word shows on the pins
    cfg <= 5'h00;
    cs_b <= 1'b0;
    rd_b <= 1'b0;
    tick(20);
    cmp(16'(pins.o), 16'h0001, "drained last word");
    cmp(16'(res_ready), 16'h0001, "queue empty again");
    cs_b <= 1'b1;
    tick(6);
    cmp(16'(pins.oe), 16'h0000, "chip select high");
    print_verdict();
  end
endmodule : tb_top
